// ===== rtl/lcd_instr_decoder.sv
// Instruction decoder, address counter and busy timing of the display controller.
// How it works
// - Host transfers other than status reads are queued by select and direction, then executed later internally.
// - Busy reads high on the top data bit during operations; host waits.
// - Clear fills display memory with spaces, zeroes the counter, forces increment.
// - Return home zeroes the counter and undoes shift; memory untouched.
// - Clear and return home each stay busy about 1.53 ms.
// - Entry mode stores direction and auto shift flags.
// - Memory accesses step the counter up or down by the direction flag.
// - Glyph memory accesses step the counter the same way.
// - Apart from shift codes, display shifts only on display memory writes with auto shift set.
// - Display control stores display on, cursor on and blink bits.
// - Shift code moves cursor or display, keeps memory, busy about 39 us.
// - Function set stores bus width, line count and font size.
// - Glyph address code loads six bits and selects glyph memory.
// - Display address code loads seven bits and selects display memory.
// - Status read returns busy and counter, allowed anytime, adds no busy.
// - Data write stores a byte in selected memory, busy about 43 us.
// - Data read returns a byte from selected memory, busy about 43 us.
// - Entry mode, function set and address codes stay busy about 39 us.
// - Narrow mode uses upper four lines, two transfers per byte.
// - Display off blanks the view but keeps display memory.
// - Cursor shift left lowers the counter, right raises it, by one.
// - The latest address code decides which memory data transfers use; clear selects display memory.
module lcd_instr_decoder
   import lcd_ctrl_pkg::*;
#(
   parameter int CLEAR_CNT = CLEAR_CYCLES,
   parameter int CMD_CNT = CMD_CYCLES,
   parameter int DATA_CNT = DATA_CYCLES
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Host parallel bus.
   input wire logic register_select,
   input wire logic read_write,
   input wire logic enable,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out_q,
   output logic data_oe_q,
   // Display settings and state.
   output logic busy_q,
   output logic display_on_q,
   output logic cursor_on_q,
   output logic cursor_blink_q,
   output logic bus_width_select_q,
   output logic two_lines_q,
   output logic tall_font_q,
   output logic [AC_W-1:0] display_offset_q,
   output logic [AC_W-1:0] address_counter_q
);
   typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_WAIT} exec_state_t;

   // Step the address counter one place in the chosen direction.
   function automatic logic [AC_W-1:0] step_ac(input logic [AC_W-1:0] ac, input logic up);
      step_ac = up ? ac + AC_ONE : ac - AC_ONE;
   endfunction : step_ac

   logic [7:0] display_memory [DISP_DEPTH];
   logic [7:0] glyph_memory [GLYPH_DEPTH];
   exec_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [AC_W-1:0] fill_q;
   logic en_q, nib_q, pend_q, sel_glyph_q, incr_q, auto_shift_flag_q;
   logic [3:0] hi_q;
   logic [Q_W-1:0] pend_data_q;
   logic q_ready, q_valid, q_pop;
   logic [Q_W-1:0] q_data;

   // Bus strobe edges and byte assembly.
   wire en_rise = enable && !en_q;
   wire en_fall = !enable && en_q;
   wire narrow = !bus_width_select_q;
   wire byte_done = en_fall && (!narrow || nib_q);
   wire [7:0] full_byte = narrow ? {hi_q, data_in[7:4]} : data_in;
   wire queue_it = byte_done && (register_select || !read_write);

   // Readback byte for the current strobe.
   wire [7:0] mem_byte = sel_glyph_q ? glyph_memory[address_counter_q[GLYPH_AW-1:0]]
                                     : display_memory[address_counter_q];
   wire [7:0] status_byte = {busy_q, address_counter_q};
   wire [7:0] rd_byte = register_select ? mem_byte : status_byte;
   wire [7:0] rd_lane = !narrow ? rd_byte : (nib_q ? {rd_byte[3:0], NIB_ZERO}
                                                  : {rd_byte[7:4], NIB_ZERO});

   // Decode of the popped entry by highest set bit.
   wire [7:0] op = q_data[7:0];
   wire is_instr = !q_data[Q_RS] && !q_data[Q_RW];
   wire is_dwr = q_data[Q_RS] && !q_data[Q_RW];
   wire is_drd = q_data[Q_RS] && q_data[Q_RW];
   wire d_ddaddr = op[BIT_DDADDR];
   wire d_glyph = !d_ddaddr && op[BIT_GLYPH];
   wire d_func = op[7:BIT_FUNC] == 3'b001;
   wire d_shift = op[7:BIT_SHIFT] == 4'b0001;
   wire d_dispctl = op[7:BIT_DISPCTL] == 5'b00001;
   wire d_entry = op[7:BIT_ENTRY] == 6'b000001;
   wire d_home = op[7:BIT_HOME] == 7'b0000001;
   wire d_clear = op == 8'h01;
   wire take = q_valid && (state_q == ST_IDLE);
   assign q_pop = take;

   lcd_fifo #(.WIDTH(Q_W), .DEPTH(Q_DEPTH)) u_queue (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(pend_q),
      .in_ready(q_ready),
      .in_data(pend_data_q),
      .out_valid(q_valid),
      .out_ready(q_pop),
      .out_data(q_data)
   );

   // Busy time chosen for each popped entry.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               state_d = ST_WAIT;
               if (!is_instr) cnt_d = CNT_W'(DATA_CNT);
               else if (d_clear) begin
                  state_d = ST_FILL;
                  cnt_d = CNT_W'(CLEAR_CNT - DISP_DEPTH);
               end else if (d_home) cnt_d = CNT_W'(CLEAR_CNT);
               else cnt_d = CNT_W'(CMD_CNT);
            end
         end
         ST_FILL: begin
            if (fill_q == AC_W'(DISP_DEPTH - 1)) state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (cnt_q <= CNT_W'(1)) state_d = ST_IDLE;
            else cnt_d = cnt_q - CNT_W'(1);
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Memory write port: fill during clear, else data writes.
   wire fill_we = (state_q == ST_FILL);
   wire data_we = take && is_dwr;
   always_ff @(posedge clk_sys) begin
      if (fill_we) display_memory[fill_q] <= SPACE_CODE;
      else if (data_we && !sel_glyph_q) display_memory[address_counter_q] <= op;
      if (data_we && sel_glyph_q) glyph_memory[address_counter_q[GLYPH_AW-1:0]] <= op;
   end

   // Host side: strobe tracking, nibble pairing, read drive and queue hand-off.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         en_q <= 1'b0;
         nib_q <= 1'b0;
         hi_q <= NIB_ZERO;
         pend_q <= 1'b0;
         pend_data_q <= '0;
         data_out_q <= 8'h00;
         data_oe_q <= 1'b0;
      end else begin
         en_q <= enable;
         data_oe_q <= enable && read_write;
         if (en_rise && read_write) data_out_q <= rd_lane;
         if (en_fall && narrow) nib_q <= !nib_q;
         if (en_fall && narrow && !nib_q) hi_q <= data_in[7:4];
         if (queue_it) begin
            pend_q <= 1'b1;
            pend_data_q <= {register_select, read_write, full_byte};
         end else if (q_ready) pend_q <= 1'b0;
      end
   end

   // Busy covers queued, pending and executing work.
   wire busy_d = pend_q || q_valid || (state_d != ST_IDLE) || queue_it;

   // Executor: address counter, flags and settings.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         fill_q <= HOME_ADDR;
         busy_q <= 1'b0;
         address_counter_q <= HOME_ADDR;
         display_offset_q <= HOME_ADDR;
         sel_glyph_q <= 1'b0;
         incr_q <= RST_INCR;
         auto_shift_flag_q <= 1'b0;
         display_on_q <= 1'b0;
         cursor_on_q <= 1'b0;
         cursor_blink_q <= 1'b0;
         bus_width_select_q <= RST_WIDTH_8;
         two_lines_q <= 1'b0;
         tall_font_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         fill_q <= fill_we ? fill_q + AC_ONE : HOME_ADDR;
         if (take && !is_instr) begin
            address_counter_q <= step_ac(address_counter_q, incr_q);
            if (is_dwr && !sel_glyph_q && auto_shift_flag_q) begin
               display_offset_q <= step_ac(display_offset_q, incr_q);
            end
         end else if (take) begin
            if (d_ddaddr) begin
               address_counter_q <= op[AC_W-1:0];
               sel_glyph_q <= 1'b0;
            end else if (d_glyph) begin
               address_counter_q <= {1'b0, op[GLYPH_AW-1:0]};
               sel_glyph_q <= 1'b1;
            end else if (d_func) begin
               bus_width_select_q <= op[F_WIDTH];
               two_lines_q <= op[F_LINES];
               tall_font_q <= op[F_FONT];
            end else if (d_shift) begin
               if (op[F_SC]) display_offset_q <= step_ac(display_offset_q, !op[F_RL]);
               else address_counter_q <= step_ac(address_counter_q, op[F_RL]);
            end else if (d_dispctl) begin
               display_on_q <= op[F_DISP_ON];
               cursor_on_q <= op[F_CURSOR_ON];
               cursor_blink_q <= op[F_BLINK];
            end else if (d_entry) begin
               incr_q <= op[F_INCR];
               auto_shift_flag_q <= op[F_AUTOSHIFT];
            end else if (d_home) begin
               address_counter_q <= HOME_ADDR;
               display_offset_q <= HOME_ADDR;
            end else if (d_clear) begin
               address_counter_q <= HOME_ADDR;
               display_offset_q <= HOME_ADDR;
               incr_q <= 1'b1;
               sel_glyph_q <= 1'b0;
            end
         end
      end
   end

   // Checks on the decoder.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_busy_after_queue: assert property (queue_it |=> busy_q)
      else $error("busy not raised after a queued transfer");
   chk_status_read: assert property (en_rise && read_write && !register_select && !narrow
      |=> data_out_q == {$past(busy_q), $past(address_counter_q)})
      else $error("status read returned wrong value");
   chk_clear_home: assert property (take && is_instr && d_clear
      |=> address_counter_q == HOME_ADDR && incr_q && state_q == ST_FILL)
      else $error("clear did not home counter or force increment");
   chk_home_undo: assert property (take && is_instr && d_home
      |=> address_counter_q == HOME_ADDR && display_offset_q == HOME_ADDR)
      else $error("return home left counter or offset");
   chk_entry_flags: assert property (take && is_instr && d_entry
      |=> incr_q == $past(op[F_INCR]) && auto_shift_flag_q == $past(op[F_AUTOSHIFT]))
      else $error("entry mode flags not stored");
   chk_dispctl_bits: assert property (take && is_instr && d_dispctl
      |=> {display_on_q, cursor_on_q, cursor_blink_q} == $past(op[2:0]))
      else $error("display control bits not stored");
   chk_ddaddr_load: assert property (take && is_instr && d_ddaddr
      |=> address_counter_q == $past(op[6:0]) && !sel_glyph_q)
      else $error("display address not loaded");
   chk_glyph_load: assert property (take && is_instr && d_glyph
      |=> address_counter_q == {1'b0, $past(op[5:0])} && sel_glyph_q)
      else $error("glyph address not loaded");
   chk_data_step: assert property (take && !is_instr && incr_q
      |=> address_counter_q == $past(address_counter_q) + AC_ONE)
      else $error("counter did not step up after data access");
   chk_read_no_shift: assert property (take && is_drd |=> $stable(display_offset_q))
      else $error("display shifted on a read");
   chk_cmd_busy: assert property (take && is_instr && d_entry |=> busy_q [*8])
      else $error("entry mode did not hold busy");

   // Downward stepping, the clear walk and the remaining settings.
   chk_data_step_down: assert property (take && !is_instr && !incr_q
      |=> address_counter_q == $past(address_counter_q) - AC_ONE)
      else $error("counter did not step down after data access");
   chk_fill_walk: assert property (fill_we && fill_q != AC_W'(DISP_DEPTH - 1)
      |=> fill_we && fill_q == $past(fill_q) + AC_ONE)
      else $error("clear skipped a display memory location");
   chk_shift_keeps_ac: assert property (take && is_instr && d_shift && op[F_SC]
      |=> $stable(address_counter_q))
      else $error("display shift moved the address counter");
   chk_func_bits: assert property (take && is_instr && d_func
      |=> {bus_width_select_q, two_lines_q, tall_font_q} == $past(op[F_WIDTH:F_FONT]))
      else $error("function set bits not stored");

   // Coverage of the main scenarios.
   cov_clear: cover property (take && is_instr && d_clear ##1 state_q == ST_FILL);
   cov_narrow_write: cover property (narrow && queue_it && !read_write);
   cov_glyph_write: cover property (take && is_dwr && sel_glyph_q);
   cov_home: cover property (take && is_instr && d_home);
   cov_narrow_read: cover property (narrow && en_rise && read_write && register_select);
endmodule : lcd_instr_decoder

// ===== rtl/lcd_ctrl_pkg.sv
// Shared constants for the character display instruction decoder.
package lcd_ctrl_pkg;
   // Clock period of clk_sys in picoseconds (125 MHz).
   localparam int CLK_PERIOD_PS = 8000;
   // Execution times for the 270 kHz oscillator, each in the unit that its suffix names.
   localparam int T_CLEAR_NS = 1530000;
   localparam int T_CMD_US = 39;
   localparam int T_DATA_US = 43;
   // Least busy times rounded up to whole clk_sys cycles.
   localparam int CLEAR_CYCLES = (T_CLEAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CMD_CYCLES = (T_CMD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DATA_CYCLES = (T_DATA_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 20;
   // Memory sizes and address widths.
   localparam int AC_W = 7;
   localparam int DISP_DEPTH = 128;
   localparam int GLYPH_DEPTH = 64;
   localparam int GLYPH_AW = 6;
   // Instruction bit positions: the highest set bit names the instruction.
   localparam int BIT_CLEAR = 0;
   localparam int BIT_HOME = 1;
   localparam int BIT_ENTRY = 2;
   localparam int BIT_DISPCTL = 3;
   localparam int BIT_SHIFT = 4;
   localparam int BIT_FUNC = 5;
   localparam int BIT_GLYPH = 6;
   localparam int BIT_DDADDR = 7;
   // Field positions inside instruction bytes.
   localparam int F_INCR = 1;
   localparam int F_AUTOSHIFT = 0;
   localparam int F_DISP_ON = 2;
   localparam int F_CURSOR_ON = 1;
   localparam int F_BLINK = 0;
   localparam int F_SC = 3;
   localparam int F_RL = 2;
   localparam int F_WIDTH = 4;
   localparam int F_LINES = 3;
   localparam int F_FONT = 2;
   // Data values and reset values.
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [6:0] HOME_ADDR = 7'h00;
   localparam logic [6:0] AC_ONE = 7'h01;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic RST_WIDTH_8 = 1'b1;
   localparam logic RST_INCR = 1'b1;
   // Queue entry layout: {register_select, read_write, byte}.
   localparam int Q_W = 10;
   localparam int Q_DEPTH = 16;
   localparam int Q_RS = 9;
   localparam int Q_RW = 8;
endpackage : lcd_ctrl_pkg

// ===== rtl/lcd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
module lcd_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full and empty follow the occupancy count.
   assign in_ready = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data = store[rd_q];

   // Storage array, no reset needed.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         store[wr_q] <= in_data;
      end
   end

   // Pointers wrap at DEPTH.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : lcd_fifo

// ===== dv/lcd_host_model.sv
// Host processor model that drives the display controller's parallel bus.
module lcd_host_model (
   // Clock.
   input wire logic clk_sys,
   // Bus toward the controller.
   output logic register_select,
   output logic read_write,
   output logic enable,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out_q,
   input wire logic data_oe_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // Half an oscillator period at 270 kHz in 8 ns cycles, and the poll limit.
   localparam int HALF_OSC_CYC = 232;
   localparam int POLL_MAX = 4000;
   logic narrow = 1'b0;
   logic timed_out = 1'b0;
   // Output enable seen while the last strobe was high.
   logic oe_seen = 1'b0;
   // Bus idles with the strobe low.
   initial begin
      register_select = 1'b0;
      read_write = 1'b0;
      enable = 1'b0;
      data_in = 8'h00;
   end
   // One enable pulse; select, direction and data hold through the falling edge.
   task automatic strobe(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      #1;
      register_select = rs;
      read_write = rw;
      data_in = d;
      enable = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      q = data_out_q;
      oe_seen = data_oe_q;
      enable = 1'b0;
      @(posedge clk_sys);
      #1;
      data_in = ~d; // Released lines do not keep the last value.
   endtask : strobe
   // A whole byte: one strobe on the wide bus, upper then lower nibble on the narrow one.
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] hi;
      logic [7:0] lo;
      if (narrow) begin
         strobe(rs, rw, {d[7:4], 4'h0}, hi);
         strobe(rs, rw, {d[3:0], 4'h0}, lo);
         q = {hi[7:4], lo[7:4]};
      end else begin
         strobe(rs, rw, d, q);
      end
   endtask : xfer
   // Polls status until busy reads low, then lets half an oscillator period pass.
   task automatic wait_ready();
      logic [7:0] st;
      int n;
      st = 8'h80;
      n = 0;
      while (st[7] !== 1'b0 && n < POLL_MAX) begin
         xfer(1'b0, 1'b1, 8'h00, st);
         n++;
      end
      if (n >= POLL_MAX) timed_out = 1'b1;
      repeat (HALF_OSC_CYC) @(posedge clk_sys);
   endtask : wait_ready
endmodule : lcd_host_model

// ===== dv/char_lcd_instruction_decoder_tb.sv
// Self-checking bench for the display controller instruction decoder.
module char_lcd_instruction_decoder_tb
   import lcd_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Shortened execution counts.
   localparam int CLR = 300;
   localparam int CMD = 20;
   localparam int DAT = 200;
   // Cycle limit for the whole run.
   localparam int WD_CYC = 60000;
   logic clk_sys, rst_b, register_select, read_write, enable, data_oe_q, busy_q;
   logic display_on_q, cursor_on_q, cursor_blink_q, bus_width_select_q, two_lines_q, tall_font_q;
   logic [7:0] data_in, data_out_q, q;
   logic [6:0] display_offset_q, address_counter_q;
   int n_mismatch = 0;
   int n_compared = 0;
   int busy_run = 0;
   int busy_len = 0;
   logic [7:0] sh_code [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
   logic [6:0] sh_ac [4] = '{7'h10, 7'h11, 7'h11, 7'h11};
   logic [6:0] sh_off [4] = '{7'h00, 7'h00, 7'h01, 7'h00};
   lcd_instr_decoder #(.CLEAR_CNT(CLR), .CMD_CNT(CMD), .DATA_CNT(DAT)) lcd_instr_decoder_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .register_select(register_select), .read_write(read_write),
      .enable(enable), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
      .busy_q(busy_q), .display_on_q(display_on_q), .cursor_on_q(cursor_on_q),
      .cursor_blink_q(cursor_blink_q), .bus_width_select_q(bus_width_select_q),
      .two_lines_q(two_lines_q), .tall_font_q(tall_font_q), .display_offset_q(display_offset_q),
      .address_counter_q(address_counter_q));
   lcd_host_model lcd_host_model_i (
      .clk_sys(clk_sys), .register_select(register_select), .read_write(read_write),
      .enable(enable), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q));
   // Clock at 125 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Measures how long each busy period lasts.
   always @(posedge clk_sys) begin
      if (busy_q === 1'b1) busy_run <= busy_run + 1;
      else if (busy_run != 0) begin
         busy_len <= busy_run;
         busy_run <= 0;
      end
   end
   // Compares a value seen at the ports.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Compares a busy duration against its least count plus a small margin.
   task automatic chk_len(input string nm, input int e, input int g);
      n_compared++;
      if (g < e || g > e + 8) begin
         n_mismatch++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_len
   // Writes a byte and waits until the controller is ready again.
   task automatic cmd(input logic rs, input logic [7:0] d);
      lcd_host_model_i.xfer(rs, 1'b0, d, q);
      lcd_host_model_i.wait_ready();
   endtask : cmd
   // Reads a byte into q and waits until ready.
   task automatic rd(input logic rs);
      lcd_host_model_i.xfer(rs, 1'b1, 8'h00, q);
      lcd_host_model_i.wait_ready();
   endtask : rd
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      if (lcd_host_model_i.timed_out) n_mismatch++;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // Cuts a hang or a polling timeout short; either one counts as a mismatch.
   initial begin
      for (int i = 0; i < WD_CYC && !lcd_host_model_i.timed_out; i++) begin
         @(posedge clk_sys);
      end
      if (!lcd_host_model_i.timed_out) n_mismatch++;
      results();
   end
   // Main sequence.
   initial begin
      rst_b = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      chk("flags", 8'h04, {1'b0, busy_q, display_on_q, cursor_on_q, cursor_blink_q, bus_width_select_q,
         two_lines_q, tall_font_q});
      cmd(1'b0, 8'h85);
      chk("ac", {1'b0, HOME_ADDR + 7'h05}, {1'b0, address_counter_q});
      chk_len("addr busy", CMD, busy_len);
      rd(1'b0);
      chk("status", 8'h05, q);
      lcd_host_model_i.xfer(1'b1, 1'b0, 8'h41, q);
      chk("oe", 8'h00, {7'h00, lcd_host_model_i.oe_seen});
      lcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, q);
      chk("busy bit", 8'h80, q & 8'h80);
      chk("oe", 8'h01, {7'h00, lcd_host_model_i.oe_seen});
      lcd_host_model_i.wait_ready();
      chk_len("write busy", DAT, busy_len);
      cmd(1'b1, 8'h42);
      chk("ac", 8'h07, {1'b0, address_counter_q});
      cmd(1'b0, 8'h04);
      cmd(1'b1, 8'h43);
      chk("ac", 8'h06, {1'b0, address_counter_q});
      cmd(1'b0, 8'h86);
      rd(1'b1);
      chk("data", 8'h42, q);
      chk("ac", 8'h05, {1'b0, address_counter_q});
      chk_len("read busy", DAT, busy_len);
      cmd(1'b0, 8'h90);
      cmd(1'b0, 8'h07);
      cmd(1'b1, 8'h44);
      chk("offset", 8'h01, {1'b0, display_offset_q});
      cmd(1'b0, 8'h05);
      cmd(1'b1, 8'h45);
      chk("offset", 8'h00, {1'b0, display_offset_q});
      cmd(1'b0, 8'h07);
      rd(1'b1);
      chk("offset", 8'h00, {1'b0, display_offset_q});
      for (int i = 0; i < 4; i++) begin
         cmd(1'b0, sh_code[i]);
         chk("ac", {1'b0, sh_ac[i]}, {1'b0, address_counter_q});
         chk("offset", {1'b0, sh_off[i]}, {1'b0, display_offset_q});
         chk_len("shift busy", CMD, busy_len);
      end
      cmd(1'b0, 8'h0F);
      chk("display", 8'h07, {5'h00, display_on_q, cursor_on_q, cursor_blink_q});
      cmd(1'b0, 8'h0B);
      chk("display", 8'h03, {5'h00, display_on_q, cursor_on_q, cursor_blink_q});
      cmd(1'b0, 8'h3C);
      chk("function", 8'h07, {5'h00, bus_width_select_q, two_lines_q, tall_font_q});
      cmd(1'b0, 8'h7F);
      chk("ac", 8'h3F, {1'b0, address_counter_q});
      cmd(1'b0, 8'h45);
      cmd(1'b1, 8'h1A);
      chk("ac", 8'h06, {1'b0, address_counter_q});
      cmd(1'b0, 8'h45);
      rd(1'b1);
      chk("glyph", 8'h1A, q);
      cmd(1'b0, 8'h85);
      rd(1'b1);
      chk("data", 8'h41, q);
      cmd(1'b0, 8'h18);
      cmd(1'b0, 8'h03);
      chk("home", 8'h00, {address_counter_q, 1'b0} | {1'b0, display_offset_q});
      chk_len("home busy", CLR, busy_len);
      cmd(1'b0, 8'h85);
      rd(1'b1);
      chk("data", 8'h41, q);
      cmd(1'b0, 8'h04);
      cmd(1'b0, 8'h01);
      chk("ac", 8'h00, {1'b0, address_counter_q});
      chk_len("clear busy", CLR, busy_len);
      cmd(1'b0, 8'h85);
      rd(1'b1);
      chk("data", SPACE_CODE, q);
      chk("ac", 8'h06, {1'b0, address_counter_q});
      cmd(1'b0, 8'h80);
      for (int i = 0; i < 20; i++) lcd_host_model_i.xfer(1'b1, 1'b0, 8'h30, q);
      repeat (18 * (DAT + 10)) @(posedge clk_sys);
      lcd_host_model_i.wait_ready();
      chk("ac", 8'h12, {1'b0, address_counter_q});
      lcd_host_model_i.xfer(1'b0, 1'b0, 8'h28, q);
      repeat (CMD + 40) @(posedge clk_sys);
      chk("width", 8'h00, {7'h00, bus_width_select_q});
      lcd_host_model_i.narrow = 1'b1;
      cmd(1'b0, 8'hC0);
      chk("ac", 8'h40, {1'b0, address_counter_q});
      cmd(1'b1, 8'h5A);
      cmd(1'b0, 8'hC0);
      rd(1'b1);
      chk("data", 8'h5A, q);
      rd(1'b0);
      chk("status", 8'h41, q);
      results();
   end
endmodule : char_lcd_instruction_decoder_tb
